// >>> rtl/ldocd_regs.svh
/*
 * Register map constants for the regulator control and discharge bank.
 * Assumes a byte-wide register pointer and 8-bit registers.
 */
`ifndef LDOCD_REGS_SVH
`define LDOCD_REGS_SVH

// Register offsets
`define LDOCD_LDO_B_CONTROL_OFS   8'h28
`define LDOCD_LDO_C_CONTROL_OFS   8'h29
`define LDOCD_DISCH_ONE_OFS       8'h40
`define LDOCD_DISCH_TWO_OFS       8'h41

// Reset values
`define LDOCD_LDO_B_CONTROL_RST   8'h0c
`define LDOCD_LDO_C_CONTROL_RST   8'h3c
`define LDOCD_DISCH_ONE_RST       8'h55
`define LDOCD_DISCH_TWO_RST       8'h55

// Control register fields
`define LDOCD_SLP_EN_MSB          5
`define LDOCD_SLP_EN_LSB          4
`define LDOCD_RSVD_MSB            3
`define LDOCD_RSVD_LSB            1
`define LDOCD_ENABLE_BIT          0
`define LDOCD_CTRL_STORED_W       6

// Discharge codes
`define LDOCD_DIS_NONE            2'h0
`define LDOCD_DIS_100             2'h1
`define LDOCD_DIS_200             2'h2
`define LDOCD_DIS_500             2'h3

// Serial interface framing
`define LDOCD_BYTE_LAST_BIT       3'h7

`endif

// >>> rtl/ldocd_pkg.sv
/*
 * Types for the regulator control and discharge bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ldocd_pkg;

    typedef enum logic [3:0] {
        LDOCD_IDLE,
        LDOCD_ADDR,
        LDOCD_ADDR_ACK,
        LDOCD_REG,
        LDOCD_REG_ACK,
        LDOCD_WDATA,
        LDOCD_WDATA_ACK,
        LDOCD_RDATA,
        LDOCD_RDATA_ACK
    } ldocd_state_t;

    typedef logic [1:0] ldocd_dis_t;

endpackage

// >>> rtl/ldocd_rail_if.sv
/*
 * Carrier between the register bank and the discharge decoder.
 * Assumes eight discharge rails.
 */
`timescale 1ns/100ps
`default_nettype none

interface ldocd_rail_if;
    import ldocd_pkg::*;
    ldocd_dis_t  field [8];
    logic [7:0]  rail_en;
    logic [7:0]  dis_100;
    logic [7:0]  dis_200;
    logic [7:0]  dis_500;

    modport bank (output field, output rail_en, input dis_100, input dis_200, input dis_500);
    modport dec  (input field, input rail_en, output dis_100, output dis_200, output dis_500);
endinterface

`default_nettype wire

// >>> rtl/ldocd_discharge_dec.sv
/*
 * Decodes each rail discharge field into resistor path enables.
 * Assumes the bank supplies fields and rail enable levels on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ldocd_regs.svh"

module ldocd_discharge_dec (
    // Clock and reset
    input  wire logic      mclk,
    input  wire logic      reset_n,
    input  wire logic      ce,
    // Bank side
    ldocd_rail_if.dec      rail
);
    import ldocd_pkg::*;

    logic [7:0] d100_nxt;
    logic [7:0] d200_nxt;
    logic [7:0] d500_nxt;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_rail
            // Enabled rail has its paths cleared at the next mclk edge, so outputs lag rail_en one cycle
            always_comb begin
                d100_nxt[g] = !rail.rail_en[g] && rail.field[g] == `LDOCD_DIS_100;
                d200_nxt[g] = !rail.rail_en[g] && rail.field[g] == `LDOCD_DIS_200;
                d500_nxt[g] = !rail.rail_en[g] && rail.field[g] == `LDOCD_DIS_500;
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rail.dis_100 <= 8'h00;
            rail.dis_200 <= 8'h00;
            rail.dis_500 <= 8'h00;
        end else if (ce) begin
            rail.dis_100 <= d100_nxt;
            rail.dis_200 <= d200_nxt;
            rail.dis_500 <= d500_nxt;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/ldocd_bank.sv
/*
 * Regulator control and discharge register bank behind a two-wire serial
 * register port, with regulator gating and discharge path outputs.
 * Assumes scl and sda are already synchronous to mclk; the sleep pin and
 * sequencer requests come from elsewhere in the device.
 */
// Function
// - Bits 5-4 of ldo_c_control enable sleep switching when nonzero, triggered by the sleep pin.
// - ldo_b_control has the same two-bit sleep enable field, resetting to 0h.
// - Bits 3-1 of ldo_c_control are a stored reserved field; low values make voltage settings ignored.
// - Bits 3-1 of ldo_b_control behave the same way for the second regulator.
// - Bit 0 of ldo_c_control cleared forces that regulator off over every control pin; reset 0.
// - Bit 0 of ldo_b_control cleared forces that regulator off over every control pin; reset 0.
// - Each discharge field selects none, 100, 200 or 500 ohm for its rail.
// - An enabled rail has its discharge field forced to zero.
// - discharge_control_one holds buck four to one fields at bits 7-6 down to 1-0, each reset 1h.
// - discharge_control_two holds ldo_b, load switch, buck six, buck five fields, each reset 1h.
`timescale 1ns/100ps
`default_nettype none
`include "ldocd_regs.svh"

module ldocd_bank #(
    parameter logic [6:0] DEV_ADDR  = 7'h5e,
    parameter bit         LDO_B_PIN = 1'b0,
    parameter bit         LDO_C_PIN = 1'b1
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    // Serial register port
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Control pins and sequencer
    input  wire logic        sleep_pin_one,
    input  wire logic        sleep_pin_two,
    input  wire logic        ldo_b_request,
    input  wire logic        ldo_c_request,
    input  wire logic [6:0]  rail_on,
    // Regulator controls
    output logic             ldo_b_on,
    output logic             ldo_c_on,
    output logic             ldo_b_sleep,
    output logic             ldo_c_sleep,
    output logic             ldo_b_vid_valid,
    output logic             ldo_c_vid_valid,
    // Discharge paths, bit per rail
    output logic [7:0]       dis_100,
    output logic [7:0]       dis_200,
    output logic [7:0]       dis_500
);
    import ldocd_pkg::*;

    ldocd_rail_if rail ();

    ldocd_state_t state_r, state_nxt;
    logic         scl_r, sda_r;
    logic [2:0]   bit_r, bit_nxt;
    logic [7:0]   shift_r, shift_nxt;
    logic [7:0]   ptr_r, ptr_nxt;
    logic         rw_r, rw_nxt;
    logic         ack_r, ack_nxt;
    logic         oe_r, oe_nxt;
    logic         mack_r, mack_nxt;
    logic         scl_rise, scl_fall, start_c, stop_c;
    logic [7:0]   byte_in;
    logic         wr_stb;
    logic [7:0]   rd_data;

    logic [5:0]   ldo_b_r, ldo_b_nxt;
    logic [5:0]   ldo_c_r, ldo_c_nxt;
    logic [7:0]   disch1_r, disch1_nxt;
    logic [7:0]   disch2_r, disch2_nxt;
    logic         b_on_r, b_on_nxt, c_on_r, c_on_nxt;
    logic         b_slp_r, b_slp_nxt, c_slp_r, c_slp_nxt;
    logic         b_vv_r, b_vv_nxt, c_vv_r, c_vv_nxt;

    // Inputs are synchronous, so one stage gives edge history only
    assign scl_rise = scl && !scl_r;
    assign scl_fall = !scl && scl_r;
    assign start_c  = scl && scl_r && sda_r && !sda_in;
    assign stop_c   = scl && scl_r && !sda_r && sda_in;
    assign byte_in  = {shift_r[6:0], sda_in};
    assign wr_stb   = state_r == LDOCD_WDATA && scl_rise && bit_r == `LDOCD_BYTE_LAST_BIT;

    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `LDOCD_LDO_B_CONTROL_OFS: v = {2'b00, ldo_b_r};
            `LDOCD_LDO_C_CONTROL_OFS: v = {2'b00, ldo_c_r};
            `LDOCD_DISCH_ONE_OFS:     v = disch1_r;
            `LDOCD_DISCH_TWO_OFS:     v = disch2_r;
            default:                  v = 8'h00;
        endcase
        return v;
    endfunction

    // Process form, so a register update alone refreshes the read byte
    always_comb rd_data = read_reg(ptr_r);

    // Serial protocol engine
    always_comb begin
        state_nxt = state_r;
        bit_nxt   = bit_r;
        shift_nxt = shift_r;
        ptr_nxt   = ptr_r;
        rw_nxt    = rw_r;
        ack_nxt   = ack_r;
        oe_nxt    = oe_r;
        mack_nxt  = mack_r;
        if (start_c) begin
            state_nxt = LDOCD_ADDR;
            bit_nxt   = 3'h0;
            ack_nxt   = 1'b0;
            oe_nxt    = 1'b0;
        end else if (stop_c) begin
            state_nxt = LDOCD_IDLE;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                LDOCD_IDLE: begin
                    oe_nxt = 1'b0;
                end
                LDOCD_ADDR, LDOCD_REG, LDOCD_WDATA: begin
                    if (scl_rise) begin
                        shift_nxt = byte_in;
                        bit_nxt   = bit_r + 3'h1;
                        if (bit_r == `LDOCD_BYTE_LAST_BIT) begin
                            ack_nxt = 1'b0;
                            if (state_r == LDOCD_ADDR) begin
                                rw_nxt    = sda_in;
                                // Other addresses: stay silent until next start
                                state_nxt = (shift_r[6:0] == DEV_ADDR) ? LDOCD_ADDR_ACK
                                                                         : LDOCD_IDLE;
                            end else if (state_r == LDOCD_REG) begin
                                ptr_nxt   = byte_in;
                                state_nxt = LDOCD_REG_ACK;
                            end else begin
                                ptr_nxt   = ptr_r + 8'h01;
                                state_nxt = LDOCD_WDATA_ACK;
                            end
                        end
                    end
                end
                LDOCD_ADDR_ACK, LDOCD_REG_ACK, LDOCD_WDATA_ACK: begin
                    if (scl_fall) begin
                        if (!ack_r) begin
                            ack_nxt = 1'b1;
                            oe_nxt  = 1'b1;
                        end else begin
                            ack_nxt = 1'b0;
                            bit_nxt = 3'h0;
                            if (state_r == LDOCD_ADDR_ACK && rw_r) begin
                                shift_nxt = rd_data;
                                ptr_nxt   = ptr_r + 8'h01;
                                oe_nxt    = !rd_data[7];
                                state_nxt = LDOCD_RDATA;
                            end else begin
                                oe_nxt    = 1'b0;
                                state_nxt = (state_r == LDOCD_ADDR_ACK) ? LDOCD_REG
                                                                          : LDOCD_WDATA;
                            end
                        end
                    end
                end
                LDOCD_RDATA: begin
                    if (scl_rise) begin
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == `LDOCD_BYTE_LAST_BIT) begin
                            ack_nxt   = 1'b0;
                            state_nxt = LDOCD_RDATA_ACK;
                        end
                    end else if (scl_fall) begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        oe_nxt    = !shift_r[6];
                    end
                end
                LDOCD_RDATA_ACK: begin
                    if (scl_fall && !ack_r) begin
                        ack_nxt = 1'b1;
                        oe_nxt  = 1'b0;
                    end else if (scl_rise) begin
                        mack_nxt = !sda_in;
                    end else if (scl_fall) begin
                        ack_nxt = 1'b0;
                        bit_nxt = 3'h0;
                        if (mack_r) begin
                            shift_nxt = rd_data;
                            ptr_nxt   = ptr_r + 8'h01;
                            oe_nxt    = !rd_data[7];
                            state_nxt = LDOCD_RDATA;
                        end else begin
                            state_nxt = LDOCD_IDLE;
                        end
                    end
                end
                default: begin
                    state_nxt = LDOCD_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= LDOCD_IDLE;
            scl_r   <= 1'b1;
            sda_r   <= 1'b1;
            bit_r   <= 3'h0;
            shift_r <= 8'h00;
            ptr_r   <= 8'h00;
            rw_r    <= 1'b0;
            ack_r   <= 1'b0;
            oe_r    <= 1'b0;
            mack_r  <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            scl_r   <= scl;
            sda_r   <= sda_in;
            bit_r   <= bit_nxt;
            shift_r <= shift_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            ack_r   <= ack_nxt;
            oe_r    <= oe_nxt;
            mack_r  <= mack_nxt;
        end
    end

    // Register file and regulator gating
    always_comb begin
        ldo_b_nxt  = ldo_b_r;
        ldo_c_nxt  = ldo_c_r;
        disch1_nxt = disch1_r;
        disch2_nxt = disch2_r;
        if (wr_stb) begin
            case (ptr_r)
                // Reserved bits 3-1 stored as written; host must keep them
                `LDOCD_LDO_B_CONTROL_OFS: ldo_b_nxt = byte_in[5:0];
                `LDOCD_LDO_C_CONTROL_OFS: ldo_c_nxt = byte_in[5:0];
                `LDOCD_DISCH_ONE_OFS:     disch1_nxt = byte_in;
                `LDOCD_DISCH_TWO_OFS:     disch2_nxt = byte_in;
                default:                  ldo_b_nxt = ldo_b_r;
            endcase
        end
        // Clear beats a same-cycle write while the rail is up
        for (int i = 0; i < 4; i++) begin
            if (rail.rail_en[i]) disch1_nxt[2*i +: 2] = `LDOCD_DIS_NONE;
            if (rail.rail_en[i+4]) disch2_nxt[2*i +: 2] = `LDOCD_DIS_NONE;
        end
        // Enable bit overrides any sequencer demand from the control pins
        b_on_nxt  = ldo_b_r[`LDOCD_ENABLE_BIT] && ldo_b_request;
        c_on_nxt  = ldo_c_r[`LDOCD_ENABLE_BIT] && ldo_c_request;
        b_slp_nxt = (ldo_b_r[`LDOCD_SLP_EN_MSB:`LDOCD_SLP_EN_LSB] != 2'h0)
                    && (LDO_B_PIN ? sleep_pin_two : sleep_pin_one);
        c_slp_nxt = (ldo_c_r[`LDOCD_SLP_EN_MSB:`LDOCD_SLP_EN_LSB] != 2'h0)
                    && (LDO_C_PIN ? sleep_pin_two : sleep_pin_one);
        b_vv_nxt  = ldo_b_r[`LDOCD_RSVD_MSB:`LDOCD_RSVD_MSB-1] == 2'h3;
        c_vv_nxt  = ldo_c_r[`LDOCD_RSVD_MSB:`LDOCD_RSVD_MSB-1] == 2'h3;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ldo_b_r  <= 6'(`LDOCD_LDO_B_CONTROL_RST);
            ldo_c_r  <= 6'(`LDOCD_LDO_C_CONTROL_RST);
            disch1_r <= `LDOCD_DISCH_ONE_RST;
            disch2_r <= `LDOCD_DISCH_TWO_RST;
            b_on_r   <= 1'b0;
            c_on_r   <= 1'b0;
            b_slp_r  <= 1'b0;
            c_slp_r  <= 1'b0;
            b_vv_r   <= 1'b0;
            c_vv_r   <= 1'b0;
        end else if (ce) begin
            ldo_b_r  <= ldo_b_nxt;
            ldo_c_r  <= ldo_c_nxt;
            disch1_r <= disch1_nxt;
            disch2_r <= disch2_nxt;
            b_on_r   <= b_on_nxt;
            c_on_r   <= c_on_nxt;
            b_slp_r  <= b_slp_nxt;
            c_slp_r  <= c_slp_nxt;
            b_vv_r   <= b_vv_nxt;
            c_vv_r   <= c_vv_nxt;
        end
    end

    // Rail order: buck1..buck4, buck5, buck6, load switch, ldo_b
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            rail.field[i]   = disch1_r[2*i +: 2];
            rail.field[i+4] = disch2_r[2*i +: 2];
        end
        rail.rail_en = {b_on_r, rail_on};
    end

    ldocd_discharge_dec u_dec (
        .mclk    (mclk),
        .reset_n (reset_n),
        .ce      (ce),
        .rail    (rail)
    );

    assign sda_out         = 1'b0;
    assign sda_oe          = oe_r;
    assign ldo_b_on        = b_on_r;
    assign ldo_c_on        = c_on_r;
    assign ldo_b_sleep     = b_slp_r;
    assign ldo_c_sleep     = c_slp_r;
    assign ldo_b_vid_valid = b_vv_r;
    assign ldo_c_vid_valid = c_vv_r;
    assign dis_100         = rail.dis_100;
    assign dis_200         = rail.dis_200;
    assign dis_500         = rail.dis_500;
endmodule

`default_nettype wire

// >>> testbench/ldocd_bank_asserts.sv
/* Port checks for the regulator control and discharge bank.
   Assumes binding to ldocd_bank on mclk with reset_n async low. */
`timescale 1ns/100ps
`default_nettype none

module ldocd_bank_asserts #(
    parameter bit LDO_B_PIN = 1'b0,
    parameter bit LDO_C_PIN = 1'b1
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       ce,
    // Serial port
    input wire logic       scl,
    input wire logic       sda_oe,
    // Pins and requests
    input wire logic       sleep_pin_one,
    input wire logic       sleep_pin_two,
    input wire logic       ldo_b_request,
    input wire logic       ldo_c_request,
    input wire logic [6:0] rail_on,
    // Watched outputs
    input wire logic       ldo_b_on,
    input wire logic       ldo_c_on,
    input wire logic       ldo_b_sleep,
    input wire logic       ldo_c_sleep,
    input wire logic [7:0] dis_100,
    input wire logic [7:0] dis_200,
    input wire logic [7:0] dis_500
);
    logic pin_b;
    logic pin_c;

    assign pin_b = LDO_B_PIN ? sleep_pin_two : sleep_pin_one;
    assign pin_c = LDO_C_PIN ? sleep_pin_two : sleep_pin_one;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_ldo_c_gate: assert property ($past(ce) && ldo_c_on |-> $past(ldo_c_request))
        else $error("ldo_c on without request");
    a_ldo_b_gate: assert property ($past(ce) && ldo_b_on |-> $past(ldo_b_request))
        else $error("ldo_b on without request");
    a_sleep_c_pin: assert property ($past(ce) && ldo_c_sleep |-> $past(pin_c))
        else $error("ldo_c sleep without pin");
    a_sleep_b_pin: assert property ($past(ce) && ldo_b_sleep |-> $past(pin_b))
        else $error("ldo_b sleep without pin");
    a_dis_onehot: assert property (((dis_100 & dis_200) | (dis_100 & dis_500)
        | (dis_200 & dis_500)) == 8'h00)
        else $error("two discharge paths on one rail");
    // Two samples of the rail, since the clear and decode may sit a cycle apart
    a_rail_quiet: assert property (ce [*3] ##0 $past(reset_n, 2) |->
        ({1'b0, $past(rail_on, 2) & $past(rail_on)} & (dis_100 | dis_200 | dis_500)) == 8'h00)
        else $error("discharge on an enabled rail");
    a_ldo_b_quiet: assert property ((ce && ldo_b_on) [*3] |->
        !(dis_100[7] | dis_200[7] | dis_500[7]))
        else $error("discharge on enabled ldo_b");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("sda pull changed with scl high");
    a_ce_freeze: assert property (!$past(ce) |-> $stable(ldo_c_on) && $stable(ldo_b_on)
        && $stable(dis_100) && $stable(ldo_c_sleep))
        else $error("state moved while clock enable low");
endmodule

bind ldocd_bank ldocd_bank_asserts #(.LDO_B_PIN(LDO_B_PIN), .LDO_C_PIN(LDO_C_PIN))
    ldocd_bank_asserts_inst (.mclk, .reset_n, .ce, .scl, .sda_oe, .sleep_pin_one,
    .sleep_pin_two, .ldo_b_request, .ldo_c_request, .rail_on, .ldo_b_on, .ldo_c_on,
    .ldo_b_sleep, .ldo_c_sleep, .dis_100, .dis_200, .dis_500);

`default_nettype wire

// >>> testbench/ldocd_host.sv
/* Serial register host model, bit-banged on mclk.
   Assumes an open-drain sda wire with pull-up resolved outside. */
`timescale 1ns/100ps
`default_nettype none

module ldocd_host #(
    parameter logic [6:0] ADDR = 7'h5e
) (
    // Clock and wire level
    input  wire logic mclk,
    input  wire logic sda,
    // Driven lines
    output logic      scl,
    output logic      sda_pull
);
    int nacks = 0;

    // Called once at time zero, so one process drives both lines
    task automatic init();
        scl <= 1'b1;
        sda_pull <= 1'b0;
    endtask

    // Sda moves only mid low phase, so no false start or stop
    task automatic put_bit(input logic b);
        scl <= 1'b0;
        repeat (2) @(posedge mclk);
        sda_pull <= !b;
        repeat (2) @(posedge mclk);
        scl <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic get_bit(output logic b);
        put_bit(1'b1);
        b = sda;
    endtask

    task automatic start();
        put_bit(1'b1);
        sda_pull <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic stop();
        put_bit(1'b0);
        sda_pull <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic send(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        if (a !== 1'b0) begin
            nacks++;
        end
    endtask

    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
        start();
        send({ADDR, 1'b0});
        send(ptr);
        send(d);
        stop();
    endtask

    // Single byte read ends with a nack, as the device expects
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
        start();
        send({ADDR, 1'b0});
        send(ptr);
        start();
        send({ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(1'b1);
        stop();
    endtask
endmodule

`default_nettype wire

// >>> testbench/ldocd_bank_bench.sv
/* Self-checking bench for the regulator control and discharge bank.
   Assumes the host model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none

module ldocd_bank_bench;
    logic       mclk = 1'b0;
    logic       reset_n, ce, scl, sda_pull, sda_out, sda_oe;
    logic       sleep_pin_one, sleep_pin_two, ldo_b_request, ldo_c_request;
    logic [6:0] rail_on;
    logic       ldo_b_on, ldo_c_on, ldo_b_sleep, ldo_c_sleep;
    logic       ldo_b_vid_valid, ldo_c_vid_valid;
    logic [7:0] dis_100, dis_200, dis_500;
    wire logic  sda;
    int         num_errors = 0;
    int         check_count = 0;
    int         cycles = 0;

    // Open drain with pull-up: a released line reads high
    assign sda = !((sda_oe && !sda_out) || sda_pull);

    ldocd_bank ldocd_bank_inst (.mclk, .reset_n, .ce, .scl, .sda_in(sda), .sda_out, .sda_oe,
        .sleep_pin_one, .sleep_pin_two, .ldo_b_request, .ldo_c_request, .rail_on, .ldo_b_on,
        .ldo_c_on, .ldo_b_sleep, .ldo_c_sleep, .ldo_b_vid_valid, .ldo_c_vid_valid, .dis_100,
        .dis_200, .dis_500);
    ldocd_host ldocd_host_inst (.mclk, .sda, .scl, .sda_pull);

    always #10 mclk = ~mclk;

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            $display("[ERR] %0t run hung", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        ldocd_host_inst.write_reg(ptr, d);
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] v;
        ldocd_host_inst.read_reg(ptr, v);
        chk(v, exp);
    endtask

    initial begin
        ldocd_host_inst.init();
        reset_n = 1'b0;
        ce = 1'b1;
        sleep_pin_one = 1'b0;
        sleep_pin_two = 1'b0;
        ldo_b_request = 1'b0;
        ldo_c_request = 1'b0;
        rail_on = 7'h00;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(8'h28, 8'h0c);
        rd(8'h29, 8'h3c);
        rd(8'h40, 8'h55);
        rd(8'h41, 8'h55);
        rd(8'h30, 8'h00);
        chk(dis_100, 8'hff);
        chk(dis_200 | dis_500, 8'h00);
        $display("test reset done");
        ldo_b_request <= 1'b1;
        ldo_c_request <= 1'b1;
        repeat (3) @(posedge mclk);
        chk_bit(ldo_c_on, 1'b0);
        chk_bit(ldo_b_on, 1'b0);
        wr(8'h29, 8'hfd);
        chk_bit(ldo_c_on, 1'b1);
        // Clock enable low must hold the output against a dropped request
        ce <= 1'b0;
        ldo_c_request <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_bit(ldo_c_on, 1'b1);
        ce <= 1'b1;
        ldo_c_request <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(8'h29, 8'h3d);
        wr(8'h28, 8'h0d);
        chk_bit(ldo_b_on, 1'b1);
        rd(8'h41, 8'h15);
        chk(dis_100, 8'h7f);
        wr(8'h28, 8'hcc);
        wr(8'h29, 8'h3c);
        chk_bit(ldo_b_on | ldo_c_on, 1'b0);
        rd(8'h28, 8'h0c);
        $display("test enable done");
        wr(8'h40, 8'he4);
        wr(8'h41, 8'h1b);
        rd(8'h40, 8'he4);
        rd(8'h41, 8'h1b);
        chk(dis_100, 8'h42);
        chk(dis_200, 8'h24);
        chk(dis_500, 8'h18);
        rail_on <= 7'h0a;
        repeat (3) @(posedge mclk);
        chk(dis_100 | dis_500, 8'h50);
        rail_on <= 7'h00;
        rd(8'h40, 8'h20);
        $display("test discharge done");
        sleep_pin_two <= 1'b1;
        repeat (3) @(posedge mclk);
        chk_bit(ldo_c_sleep, 1'b1);
        wr(8'h29, 8'h0c);
        chk_bit(ldo_c_sleep, 1'b0);
        sleep_pin_one <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(8'h28, {2'h0, 2'(c), 4'hc});
            chk_bit(ldo_b_sleep, c != 0);
        end
        sleep_pin_one <= 1'b0;
        repeat (3) @(posedge mclk);
        chk_bit(ldo_b_sleep, 1'b0);
        $display("test sleep done");
        // All eight reserved codes, to see the voltage settings dropped for codes below 6
        for (int c = 0; c < 8; c++) begin
            wr(8'h28, {4'h0, 3'(c), 1'b0});
            wr(8'h29, {4'h0, 3'(c), 1'b0});
            chk_bit(ldo_b_vid_valid, c >= 6);
            chk_bit(ldo_c_vid_valid, c >= 6);
        end
        rd(8'h29, 8'h0e);
        wr(8'h28, 8'h0c);
        wr(8'h29, 8'h0c);
        chk(8'(ldocd_host_inst.nacks), 8'h00);
        $display("test reserved done");
        complete_run();
    end
endmodule

`default_nettype wire
